// >>> include/fhb_defs.svh
// constants for the flash host bus target
//
// What this block does
// - mode input high selects multiplexed programming mode, low selects nibble-bus mode
// - mux mode takes 11-bit halves by row/column select; column upper, row lower
// - nibble-bus address and data sampled on each rising bus clock edge
// - standby when frame high and idle; ready when frame low and bus quiet
// - program/erase sequences ride bus cycles; chip erase only in mux mode
// - read starts with start nibble 0000 under frame low, then type 010X
// - write starts with start nibble 0000 under frame low, then type 011X
// - respond only with frame low at start; last start nibble wins
// - type bits 3:2 must be 01; bit 1 is direction; bit 0 ignored
// - eight address nibbles in clocks 3-10, most significant first
// - device takes the bus in read clock 12
// - device drives sync 0000 in read clock 13
// - read byte low nibble in clock 14, high nibble in clock 15
// - device drives 1111 then releases in clock 16; host resumes in 17
// - frame low mid-cycle ends the cycle; abort nibble 1111 returns to ready
// - abort cancels only the bus cycle, read or write; internal program or erase continues
// - invalid fields or sequences give no bus indication
// - write data low then high in 11-12, turnaround, sync in 15, turnaround
// - address id bits must match strapped id, else cycle ignored
// - address bit 22 high targets array, low targets register space
// - reset or init low deselects the device and floats the nibble drivers
`ifndef FHB_DEFS_SVH
`define FHB_DEFS_SVH
`define FHB_START_NIB    4'h0
`define FHB_ABORT_NIB    4'hF
`define FHB_SYNC_NIB     4'h0
`define FHB_TAR_NIB      4'hF
`define FHB_MEM_TYPE     2'h1
`define FHB_TYPE_MEM_HI  3
`define FHB_TYPE_MEM_LO  2
`define FHB_TYPE_DIR     1
`define FHB_ADDR_NIBS    4'h8
`define FHB_ARRAY_BIT    22
`define FHB_ID_HI        21
`define FHB_ID_LO        18
`define FHB_MUX_AW       11
`define FHB_CMD_A1       16'h5555
`define FHB_CMD_A2       16'h2AAA
`define FHB_CMD_D1       8'hAA
`define FHB_CMD_D2       8'h55
`define FHB_CMD_PROG     8'hA0
`define FHB_CMD_ERASE    8'h80
`define FHB_CMD_BLK      8'h30
`define FHB_CMD_CHIP     8'h10
`endif

// >>> include/fhb_pkg.sv
// types for the flash host bus target
`default_nettype none
package fhb_pkg;
    typedef enum logic [10:0] {
        FHB_IDLE  = 11'h001,
        FHB_TYPE  = 11'h002,
        FHB_ADDR  = 11'h004,
        FHB_WDAT  = 11'h008,
        FHB_HTAR  = 11'h010,
        FHB_DTAR  = 11'h020,
        FHB_SYNC  = 11'h040,
        FHB_RDAT  = 11'h080,
        FHB_ETAR  = 11'h100,
        FHB_WAIT  = 11'h200,
        FHB_SKIP  = 11'h400
    } fhb_state_t;

    typedef enum logic [5:0] {
        FHB_C0 = 6'h01,
        FHB_C1 = 6'h02,
        FHB_C2 = 6'h04,
        FHB_C3 = 6'h08,
        FHB_C4 = 6'h10,
        FHB_C5 = 6'h20
    } fhb_cmd_t;
endpackage : fhb_pkg
`default_nettype wire

// >>> src/fhb_mux_addr.sv
// row/column address assembly for the multiplexed programming mode
`default_nettype none
`include "fhb_defs.svh"
module fhb_mux_addr #(
    parameter int AW = `FHB_MUX_AW
) (
    input  wire logic            ref_clk,
    input  wire logic            rst_b,
    input  wire logic            enable,
    input  wire logic            row_sel,
    input  wire logic [AW-1:0]   mux_addr,
    output logic      [2*AW-1:0] full_addr
);
    initial begin
        if (AW < 1) $error("fhb_mux_addr: AW must be positive");
    end

    typedef struct packed {
        logic [AW-1:0] row;
        logic [AW-1:0] col;
    } fhb_mux_st_t;

    fhb_mux_st_t s_q;
    fhb_mux_st_t s_d;

    always_comb begin
        s_d = s_q;
        if (enable) begin
            if (row_sel) begin
                s_d.row = mux_addr;
            end else begin
                s_d.col = mux_addr;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign full_addr = {s_q.col, s_q.row};
endmodule // fhb_mux_addr
`default_nettype wire

// >>> src/fhb_cmd_seq.sv
// software data protection command sequence decoder
`default_nettype none
`include "fhb_defs.svh"
module fhb_cmd_seq (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        wr_stb,
    input  wire logic [15:0] wr_addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        chip_ok,
    output logic             prog_stb,
    output logic             blk_erase_stb,
    output logic             chip_erase_stb
);
    typedef struct packed {
        fhb_pkg::fhb_cmd_t st;
        logic              pgm;
        logic              prog;
        logic              blk;
        logic              chip;
    } fhb_seq_st_t;

    fhb_seq_st_t s_q;
    fhb_seq_st_t s_d;

    function automatic logic hit(input logic [15:0] a, input logic [7:0] d,
                                 input logic [15:0] ea, input logic [7:0] ed);
        hit = (a == ea) && (d == ed);
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.prog = 1'b0;
        s_d.blk = 1'b0;
        s_d.chip = 1'b0;
        if (wr_stb) begin
            s_d.st = fhb_pkg::FHB_C0;
            s_d.pgm = 1'b0;
            unique case (s_q.st)
                fhb_pkg::FHB_C0, fhb_pkg::FHB_C3: begin
                    if (hit(wr_addr, wr_data, `FHB_CMD_A1, `FHB_CMD_D1)) begin
                        s_d.st = (s_q.st == fhb_pkg::FHB_C0) ? fhb_pkg::FHB_C1
                                                            : fhb_pkg::FHB_C4;
                    end
                end
                fhb_pkg::FHB_C1, fhb_pkg::FHB_C4: begin
                    if (hit(wr_addr, wr_data, `FHB_CMD_A2, `FHB_CMD_D2)) begin
                        s_d.st = (s_q.st == fhb_pkg::FHB_C1) ? fhb_pkg::FHB_C2
                                                            : fhb_pkg::FHB_C5;
                    end
                end
                fhb_pkg::FHB_C2: begin
                    // program pulses on the data write that follows, not on the command
                    if (hit(wr_addr, wr_data, `FHB_CMD_A1, `FHB_CMD_PROG)) begin
                        s_d.st = fhb_pkg::FHB_C5;
                        s_d.pgm = 1'b1;
                    end else if (hit(wr_addr, wr_data, `FHB_CMD_A1, `FHB_CMD_ERASE)) begin
                        s_d.st = fhb_pkg::FHB_C3;
                    end
                end
                fhb_pkg::FHB_C5: begin
                    s_d.st = fhb_pkg::FHB_C0;
                    if (s_q.pgm) begin
                        s_d.prog = 1'b1;
                    end else begin
                        s_d.blk = (wr_data == `FHB_CMD_BLK);
                        s_d.chip = chip_ok && hit(wr_addr, wr_data, `FHB_CMD_A1, `FHB_CMD_CHIP);
                    end
                end
                default: s_d.st = fhb_pkg::FHB_C0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s_q <= '{st: fhb_pkg::FHB_C0, default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign prog_stb = s_q.prog;
    assign blk_erase_stb = s_q.blk;
    assign chip_erase_stb = s_q.chip;
endmodule // fhb_cmd_seq
`default_nettype wire

// >>> src/fhb_target.sv
// nibble-bus target front end of the flash with mode and command handling
`default_nettype none
`include "fhb_defs.svh"
module fhb_target #(
    parameter int MUX_AW = `FHB_MUX_AW
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              init_b,
    input  wire logic              mode_mux,
    input  wire logic              bus_clock,
    input  wire logic              frame_n,
    input  wire logic [3:0]        nibble_bus_in,
    output logic      [3:0]        nibble_bus_out,
    output logic                   nibble_bus_oe_b,
    input  wire logic [3:0]        id_strap,
    input  wire logic              busy,
    input  wire logic              row_sel,
    input  wire logic              mux_strobe,
    input  wire logic [MUX_AW-1:0] mux_addr,
    input  wire logic              mux_we,
    input  wire logic [7:0]        mux_data,
    output logic      [31:0]       acc_addr,
    output logic                   acc_array,
    output logic                   rd_req,
    input  wire logic [7:0]        rd_data,
    output logic                   wr_stb,
    output logic      [7:0]        wr_data,
    output logic                   prog_stb,
    output logic                   blk_erase_stb,
    output logic                   chip_erase_stb,
    output logic                   standby,
    output logic                   ready
);
    initial begin
        if (MUX_AW < 1 || MUX_AW > 16) $error("fhb_target: MUX_AW out of range");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        fhb_pkg::fhb_state_t st;
        logic                clk_q;
        logic                is_wr;
        logic [3:0]          cnt;
        logic [31:0]         addr;
        logic [7:0]          data;
        logic [3:0]          nout;
        logic                oe_b;
        logic                rd_req;
        logic                wr_stb;
        logic                mux_we_q;
        logic                standby;
        logic                ready;
    } fhb_st_t;

    fhb_st_t s_q;
    fhb_st_t s_d;

    logic                  edge_rise;
    logic                  cmd_wr;
    logic [15:0]           cmd_addr;
    logic [7:0]            cmd_data;
    logic [2*MUX_AW-1:0]   mux_full;

    // inputs are synchronous, so a plain delayed copy finds the rising edge
    // rising edge sampling
    assign edge_rise = bus_clock && !s_q.clk_q;

    function automatic logic id_match(input logic [31:0] a, input logic [3:0] id);
        id_match = (a[`FHB_ID_HI:`FHB_ID_LO] == id);
    endfunction

    // ----------------------------------------------------------------
    // bus engine
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.clk_q = bus_clock;
        s_d.rd_req = 1'b0;
        s_d.wr_stb = 1'b0;
        s_d.mux_we_q = mux_we;
        if (mode_mux) begin
            s_d.st = fhb_pkg::FHB_IDLE;
            s_d.oe_b = 1'b1;
            s_d.nout = `FHB_TAR_NIB;
        end else if (edge_rise) begin
            // start with frame low; last start wins
            if (!frame_n) begin
                s_d.oe_b = 1'b1;
                s_d.st = (nibble_bus_in == `FHB_START_NIB) ? fhb_pkg::FHB_TYPE
                       : (nibble_bus_in == `FHB_ABORT_NIB) ? fhb_pkg::FHB_IDLE
                       : fhb_pkg::FHB_WAIT;
            end else begin
                unique case (s_q.st)
                    fhb_pkg::FHB_IDLE, fhb_pkg::FHB_WAIT, fhb_pkg::FHB_SKIP: begin
                        s_d.oe_b = 1'b1;
                    end
                    fhb_pkg::FHB_TYPE: begin
                        if (nibble_bus_in[`FHB_TYPE_MEM_HI:`FHB_TYPE_MEM_LO] == `FHB_MEM_TYPE) begin
                            s_d.is_wr = nibble_bus_in[`FHB_TYPE_DIR];
                            s_d.cnt = 4'h0;
                            s_d.st = fhb_pkg::FHB_ADDR;
                        end else begin
                            s_d.st = fhb_pkg::FHB_SKIP;
                        end
                    end
                    fhb_pkg::FHB_ADDR: begin
                        s_d.addr = {s_q.addr[27:0], nibble_bus_in};
                        s_d.cnt = s_q.cnt + 4'h1;
                        if (s_q.cnt == `FHB_ADDR_NIBS - 4'h1) begin
                            s_d.cnt = 4'h0;
                            if (!id_match({s_q.addr[27:0], nibble_bus_in}, id_strap)) begin
                                s_d.st = fhb_pkg::FHB_SKIP;
                            end else if (s_q.is_wr) begin
                                s_d.st = fhb_pkg::FHB_WDAT;
                            end else begin
                                s_d.st = fhb_pkg::FHB_HTAR;
                                s_d.rd_req = 1'b1;
                            end
                        end
                    end
                    fhb_pkg::FHB_WDAT: begin
                        s_d.cnt = s_q.cnt + 4'h1;
                        if (s_q.cnt == 4'h0) begin
                            s_d.data[3:0] = nibble_bus_in;
                        end else begin
                            s_d.data[7:4] = nibble_bus_in;
                            s_d.wr_stb = 1'b1;
                            s_d.cnt = 4'h0;
                            s_d.st = fhb_pkg::FHB_HTAR;
                        end
                    end
                    fhb_pkg::FHB_HTAR: begin
                        s_d.st = fhb_pkg::FHB_DTAR;
                        s_d.oe_b = 1'b0;
                        s_d.nout = `FHB_TAR_NIB;
                    end
                    fhb_pkg::FHB_DTAR: begin
                        s_d.st = fhb_pkg::FHB_SYNC;
                        s_d.nout = `FHB_SYNC_NIB;
                        if (!s_q.is_wr) begin
                            s_d.data = rd_data;
                        end
                    end
                    fhb_pkg::FHB_SYNC: begin
                        if (s_q.is_wr) begin
                            s_d.st = fhb_pkg::FHB_ETAR;
                            s_d.nout = `FHB_TAR_NIB;
                        end else begin
                            s_d.st = fhb_pkg::FHB_RDAT;
                            s_d.nout = s_q.data[3:0];
                            s_d.cnt = 4'h0;
                        end
                    end
                    fhb_pkg::FHB_RDAT: begin
                        if (s_q.cnt == 4'h0) begin
                            s_d.nout = s_q.data[7:4];
                            s_d.cnt = 4'h1;
                        end else begin
                            s_d.st = fhb_pkg::FHB_ETAR;
                            s_d.nout = `FHB_TAR_NIB;
                        end
                    end
                    fhb_pkg::FHB_ETAR: begin
                        s_d.st = fhb_pkg::FHB_IDLE;
                        s_d.oe_b = 1'b1;
                    end
                    default: begin
                        s_d.st = fhb_pkg::FHB_IDLE;
                        s_d.oe_b = 1'b1;
                    end
                endcase
            end
        end
        s_d.standby = frame_n && !busy && (s_d.st == fhb_pkg::FHB_IDLE);
        s_d.ready = !frame_n && (s_d.st == fhb_pkg::FHB_IDLE);
        if (!init_b) begin
            s_d.st = fhb_pkg::FHB_IDLE;
            s_d.oe_b = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s_q <= '{st: fhb_pkg::FHB_IDLE, nout: `FHB_TAR_NIB, oe_b: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // mux mode and command decoding
    // ----------------------------------------------------------------
    fhb_mux_addr #(
        .AW(MUX_AW)
    ) u_mux (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .enable    (mode_mux && mux_strobe),
        .row_sel   (row_sel),
        .mux_addr  (mux_addr),
        .full_addr (mux_full)
    );

    // busy work is untouched by aborts
    assign cmd_wr = mode_mux ? (mux_we && !s_q.mux_we_q) : s_q.wr_stb;
    assign cmd_addr = mode_mux ? 16'(mux_full) : s_q.addr[15:0];
    assign cmd_data = mode_mux ? mux_data : s_q.data;

    fhb_cmd_seq u_seq (
        .ref_clk        (ref_clk),
        .rst_b          (rst_b && init_b),
        .wr_stb         (cmd_wr),
        .wr_addr        (cmd_addr),
        .wr_data        (cmd_data),
        .chip_ok        (mode_mux),
        .prog_stb       (prog_stb),
        .blk_erase_stb  (blk_erase_stb),
        .chip_erase_stb (chip_erase_stb)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign nibble_bus_out = s_q.nout;
    assign nibble_bus_oe_b = s_q.oe_b;
    assign acc_addr = s_q.addr;
    assign acc_array = s_q.addr[`FHB_ARRAY_BIT];
    assign rd_req = s_q.rd_req;
    assign wr_stb = s_q.wr_stb;
    assign wr_data = s_q.data;
    assign standby = s_q.standby;
    assign ready = s_q.ready;
endmodule // fhb_target
`default_nettype wire

// >>> test/fhb_target_chk.sv
// port assertions for the flash host bus target
`default_nettype none
module fhb_target_chk (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        init_b,
    input wire logic        mode_mux,
    input wire logic        bus_clock,
    input wire logic        frame_n,
    input wire logic [3:0]  nibble_bus_out,
    input wire logic        nibble_bus_oe_b,
    input wire logic [3:0]  id_strap,
    input wire logic [31:0] acc_addr,
    input wire logic        acc_array,
    input wire logic        rd_req,
    input wire logic        wr_stb,
    input wire logic        chip_erase_stb
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // bus clock rises seen while driving; needs no reset, it follows oe_b
    logic       clk_q;
    logic [2:0] drv_q;
    logic       xfer;
    assign xfer = (rd_req || wr_stb) && !mode_mux;
    always_ff @(posedge ref_clk) begin
        clk_q <= bus_clock;
        if (nibble_bus_oe_b) drv_q <= 3'h0;
        else if (bus_clock && !clk_q) drv_q <= drv_q + 3'h1;
    end
    a_init_floats: assert property (!init_b ##1 !init_b |-> nibble_bus_oe_b)
        else $error("bus driven under init");
    a_mux_silent: assert property (mode_mux && $past(mode_mux) |-> nibble_bus_oe_b)
        else $error("bus driven in mux mode");
    a_take_ones: assert property ($fell(nibble_bus_oe_b) |-> nibble_bus_out == 4'hF)
        else $error("first driven nibble not ones");
    a_drive_slots: assert property (!nibble_bus_oe_b |-> drv_q <= 3'h4)
        else $error("bus driven too long");
    a_sync_zero: assert property (
        $past(drv_q) == 3'h0 && drv_q == 3'h1 && frame_n |-> ##[0:3] nibble_bus_out == 4'h0)
        else $error("no sync after turnaround");
    a_id_match: assert property (xfer |-> acc_addr[21:18] == id_strap)
        else $error("request on foreign id");
    a_array_bit: assert property (xfer |-> acc_array == acc_addr[22])
        else $error("array select wrong");
    a_chip_mux: assert property (chip_erase_stb |-> mode_mux)
        else $error("chip erase outside mux mode");
    a_one_pulse: assert property (xfer |=> (!rd_req && !wr_stb) [*4])
        else $error("request longer than one pulse");
endmodule // fhb_target_chk
bind fhb_target fhb_target_chk chk_i (.*);
`default_nettype wire

// >>> test/fhb_host.sv
// host bus controller model: bus clock, frame and nibble drive
`default_nettype none
module fhb_host (
    input  wire logic       ref_clk,
    input  wire logic [3:0] bus_seen,
    input  wire logic       oe_b_seen,
    output logic            bus_clock,
    output logic            frame_n,
    output logic [3:0]      nib,
    output logic            nib_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] obs [1:17];
    initial {bus_clock, frame_n, nib, nib_oe} = 7'h3F;
    // one bus clock: change while low, look at the bus as it stands at the rise
    task automatic slot(input logic fr, input logic dr, input logic [3:0] n, input int k);
        @(negedge ref_clk);
        bus_clock = 1'b0;
        frame_n   = fr;
        nib       = n;
        nib_oe    = dr;
        repeat (2) @(negedge ref_clk);
        if (k > 0) obs[k] = {oe_b_seen, bus_seen};
        bus_clock = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask
    // ab: slot that aborts, 0 for none; ns: extra start slots
    task automatic cyc(input logic [3:0] ty, input logic [31:0] a, input logic [7:0] d,
                       input int ab, input int ns);
        repeat (ns + 1) slot(1'b0, 1'b1, 4'h0, 1);
        slot(1'b1, 1'b1, ty, 2);
        for (int i = 3; i <= 10; i++) slot(1'b1, 1'b1, a[4*(10-i) +: 4], i);
        for (int i = 11; i <= 17; i++) begin
            // abort: frame low with ones, twice
            if (i == ab) begin
                repeat (2) slot(1'b0, 1'b1, 4'hF, i);
                break;
            end
            // data low then high, ones, then let go
            if (ty[1] && i < 13) slot(1'b1, 1'b1, (i == 11) ? d[3:0] : d[7:4], i);
            else if (i == (ty[1] ? 13 : 11)) slot(1'b1, 1'b1, 4'hF, i);
            else slot(1'b1, 1'b0, 4'hF, i);
        end
        slot(1'b1, 1'b1, 4'hF, 0);
    endtask
endmodule // fhb_host
`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the flash host bus target
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rst_b, init_b, mode_mux, busy, row_sel, mux_strobe, mux_we;
    logic        bus_clock, frame_n, nibble_bus_oe_b, h_oe, acc_array, rd_req, wr_stb;
    logic        prog_stb, blk_erase_stb, chip_erase_stb, standby, ready;
    logic [3:0]  nibble_bus_in, nibble_bus_out, id_strap, h_nib, pat;
    logic [7:0]  mux_data, rd_data, wr_data, wd_q;
    logic [10:0] mux_addr;
    logic [31:0] acc_addr;
    int          fails, num_checks, n_rd, n_wr, n_prog, n_blk, n_chip;
    // program, block erase, chip erase share one address list
    logic [15:0] ca [6] = '{16'h5555, 16'h2AAA, 16'h5555, 16'h5555, 16'h2AAA, 16'h5555};
    logic [7:0]  cd [3][6] = '{'{8'hAA, 8'h55, 8'hA0, 8'h30, 8'h00, 8'h00},
                               '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, 8'h30},
                               '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, 8'h10}};
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) pat <= pat + 4'h7;
    // a released bus shows a moving pattern, never the last value
    assign nibble_bus_in = !nibble_bus_oe_b ? nibble_bus_out : h_oe ? h_nib : pat;
    fhb_target DUT (.*);
    fhb_host host (.ref_clk, .bus_seen(nibble_bus_in), .oe_b_seen(nibble_bus_oe_b),
                   .bus_clock, .frame_n, .nib(h_nib), .nib_oe(h_oe));
    always @(posedge ref_clk) begin
        n_rd   <= n_rd + int'(rd_req === 1'b1);
        n_wr   <= n_wr + int'(wr_stb === 1'b1);
        n_prog <= n_prog + int'(prog_stb === 1'b1);
        n_blk  <= n_blk + int'(blk_erase_stb === 1'b1);
        n_chip <= n_chip + int'(chip_erase_stb === 1'b1);
        if (wr_stb === 1'b1) wd_q <= wr_data;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic s_read(input logic [7:0] d, input int ns);
        int r;
        logic [4:0] e [5];
        r = n_rd;
        e = '{5'h0F, 5'h00, {1'b0, d[3:0]}, {1'b0, d[7:4]}, 5'h0F};
        rd_data = d;
        host.cyc(4'h5, 32'hFFD4_1234, 8'h00, 0, ns);
        chk(n_rd - r, 1);
        chk(acc_addr, 32'hFFD4_1234);
        chk(acc_array, 1'b1);
        chk(host.obs[11][4], 1'b1);
        chk(host.obs[17][4], 1'b1);
        for (int i = 0; i < 5; i++) chk(host.obs[12 + i], e[i]);
    endtask
    // foreign type or id: no reply, no request
    task automatic s_bad();
        int r;
        logic [3:0] t [3];
        r = n_rd + n_wr;
        t = '{4'h1, 4'h9, 4'hC};
        foreach (t[i]) begin
            host.cyc(t[i], 32'hFFD4_0000, 8'h00, 0, 0);
            chk(host.obs[13][4], 1'b1);
        end
        host.cyc(4'h4, 32'hFFC0_0000, 8'h00, 0, 0);
        chk(host.obs[13][4], 1'b1);
        chk(n_rd + n_wr - r, 0);
    endtask
    // abort mid-read while busy, then a read with repeated starts
    task automatic s_abort();
        busy = 1'b1;
        host.cyc(4'h4, 32'hFFD4_0010, 8'h00, 14, 0);
        chk(host.obs[13], 5'h00);
        chk(host.obs[14][4], 1'b1);
        chk(standby, 1'b0);
        host.slot(1'b0, 1'b1, 4'hF, 0);
        chk(ready, 1'b1);
        busy = 1'b0;
        s_read(8'h3C, 2);
        chk(standby, 1'b1);
        chk(ready, 1'b0);
    endtask
    task automatic s_seq(input int k, input int n);
        int w;
        w = n_wr;
        for (int i = 0; i < n; i++) host.cyc(4'h6, {16'hFFD4, ca[i]}, cd[k][i], 0, 0);
        chk(n_wr - w, n);
        chk(wd_q, cd[k][n-1]);
        chk(host.obs[14], 5'h0F);
        chk(host.obs[15], 5'h00);
        chk(host.obs[16], 5'h0F);
    endtask
    // mux mode ignores the bus, takes chip erase
    task automatic s_mux();
        mode_mux = 1'b1;
        host.cyc(4'h4, 32'hFFD4_1234, 8'h00, 0, 0);
        chk(host.obs[13][4], 1'b1);
        for (int i = 0; i < 6; i++) begin
            @(negedge ref_clk);
            row_sel    = 1'b0;
            mux_addr   = {6'h00, ca[i][15:11]};
            mux_strobe = 1'b1;
            @(negedge ref_clk);
            row_sel  = 1'b1;
            mux_addr = ca[i][10:0];
            @(negedge ref_clk);
            mux_strobe = 1'b0;
            mux_data   = cd[2][i];
            mux_we     = 1'b1;
            repeat (2) @(negedge ref_clk);
            mux_we = 1'b0;
            repeat (2) @(negedge ref_clk);
        end
        chk(n_chip, 1);
        mode_mux = 1'b0;
    endtask
    // init low in the middle of a read reply floats the bus at once
    task automatic s_init();
        fork
            host.cyc(4'h4, 32'hFFD4_0020, 8'h00, 0, 0);
            begin
                repeat (80) @(negedge ref_clk);
                init_b = 1'b0;
                repeat (2) @(negedge ref_clk);
                chk(nibble_bus_oe_b, 1'b1);
                init_b = 1'b1;
            end
        join
        chk(host.obs[15][4], 1'b1);
    endtask
    initial begin
        repeat (90000) @(posedge ref_clk);
        fails++;
        test_done();
    end
    initial begin
        {ref_clk, rst_b, init_b, mode_mux, busy, row_sel, mux_strobe, mux_we} = 8'h20;
        {mux_addr, mux_data, rd_data, pat} = '0;
        id_strap = 4'h5;
        {fails, num_checks, n_rd, n_wr, n_prog, n_blk, n_chip} = '0;
        repeat (4) @(negedge ref_clk);
        rst_b = 1'b1;
        s_read(8'hA5, 0);
        s_bad();
        s_abort();
        s_seq(0, 4);
        chk(n_prog, 1);
        s_seq(1, 6);
        chk(n_blk, 1);
        s_seq(2, 6);
        chk(n_chip, 0);
        host.cyc(4'h7, 32'hFF94_0000, 8'h3C, 0, 0);
        chk(acc_array, 1'b0);
        s_mux();
        init_b = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(nibble_bus_oe_b, 1'b1);
        init_b = 1'b1;
        s_read(8'h96, 0);
        s_init();
        test_done();
    end
endmodule // tb
`default_nettype wire
